/* File: rtl/tcc_link_if.sv */
`default_nettype none
interface tcc_link_if;
  import tcc_pkg::*;
  logic timerActive;
  logic [PRESC_SEL_W-1:0] presSel;
  logic tick;
  logic div64;
  logic paRun;
  logic paGated;
  logic paPol;
  logic pinLevel;
  logic [CNT_W-1:0] paCount;
  logic paOvf;
  modport presc (input timerActive, input presSel, output tick, output div64);
  modport pacc (input paRun, input paGated, input paPol, input pinLevel, input div64,
    output paCount, output paOvf);
  modport core (output timerActive, output presSel, output paRun, output paGated,
    output paPol, output pinLevel, input tick, input div64, input paCount, input paOvf);
endinterface : tcc_link_if
`default_nettype wire

/* File: rtl/tcc_pkg.sv */
`default_nettype none
package tcc_pkg;
  // ==========================================================
  // bus geometry
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam int DATA_W = 32;
  // ==========================================================
  // register indexes, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_FORCE_MASK = 10'h002;
  localparam logic [IDX_W-1:0] IDX_FORCE_DATA = 10'h003;
  localparam logic [IDX_W-1:0] IDX_COUNT_HIGH = 10'h004;
  localparam logic [IDX_W-1:0] IDX_COUNT_LOW = 10'h005;
  localparam logic [IDX_W-1:0] IDX_SYS_CTRL = 10'h006;
  localparam logic [IDX_W-1:0] IDX_CHAN_CFG = 10'h008;
  localparam logic [IDX_W-1:0] IDX_CMP7 = 10'h009;
  localparam logic [IDX_W-1:0] IDX_PRESC = 10'h00A;
  localparam logic [IDX_W-1:0] IDX_PACC_CTRL = 10'h00B;
  localparam logic [IDX_W-1:0] IDX_PACC_COUNT = 10'h00C;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h00D;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h00E;
  // ==========================================================
  // field layouts
  localparam int SYS_RUN_BIT = 7;
  localparam int SYS_HALT_BIT = 6;
  localparam int CFG_DIR_LSB = 0;
  localparam int CFG_DIS_LSB = 8;
  localparam int CFG_WRAP_BIT = 16;
  localparam int PACC_RUN_BIT = 0;
  localparam int PACC_GATED_BIT = 1;
  localparam int PACC_POL_BIT = 2;
  localparam int IRQ_WRAP_BIT = 0;
  localparam int IRQ_MATCH_BIT = 1;
  localparam int IRQ_PAOVF_BIT = 2;
  localparam int IRQ_W = 3;
  localparam int PACC_CTRL_W = 3;
  // ==========================================================
  // widths and reset values
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int PRESC_SEL_W = 3;
  localparam int PRESC_CNT_W = 8;
  localparam int DIV64 = 64;
  localparam int DIV64_W = $clog2(DIV64);
  localparam logic [BYTE_W-1:0] FORCE_RST = 8'h00;
  localparam logic [BYTE_W-1:0] SYS_RST = 8'h00;
endpackage : tcc_pkg
`default_nettype wire

/* File: rtl/tcc_prescaler.sv */
`default_nettype none
module tcc_prescaler (
  input wire logic clock,
  input wire logic rstN,
  tcc_link_if.presc lnk
);
  import tcc_pkg::*;
  // ==========================================================
  // divider chain, frozen while the timer is inactive
  logic [PRESC_CNT_W-1:0] presCnt_reg;
  logic [PRESC_CNT_W-1:0] selMask;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      presCnt_reg <= '0;
    end else if (lnk.timerActive) begin
      presCnt_reg <= presCnt_reg + PRESC_CNT_W'(1);
    end
  end

  assign selMask = ~({PRESC_CNT_W{1'b1}} << lnk.presSel);
  assign lnk.tick = lnk.timerActive && ((presCnt_reg & selMask) == selMask);
  assign lnk.div64 = lnk.timerActive && (presCnt_reg[DIV64_W-1:0] == '1); // R10

  div64_gate_a: assert property (@(posedge clock) disable iff (!rstN) // R10
    !lnk.timerActive |-> !lnk.div64)
    else $error("divide-by-64 clock present while timer inactive");
endmodule : tcc_prescaler
`default_nettype wire

/* File: rtl/tcc_pulse_acc.sv */
`default_nettype none
module tcc_pulse_acc (
  input wire logic clock,
  input wire logic rstN,
  tcc_link_if.pacc lnk
);
  import tcc_pkg::*;
  // ==========================================================
  // edge counting or gated time accumulation on the ch7 pin
  logic [CNT_W-1:0] paCount_reg;
  logic pinPrev_reg;
  logic enLevel;
  logic edgeSeen;
  logic inc;

  assign enLevel = lnk.paPol ? !lnk.pinLevel : lnk.pinLevel;
  assign edgeSeen = lnk.paPol ? (lnk.pinLevel && !pinPrev_reg) : (!lnk.pinLevel && pinPrev_reg);
  assign inc = lnk.paRun && (lnk.paGated ? (lnk.div64 && enLevel) : edgeSeen); // R16

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      pinPrev_reg <= 1'b0;
    end else begin
      pinPrev_reg <= lnk.pinLevel;
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      paCount_reg <= '0;
    end else if (inc) begin
      paCount_reg <= paCount_reg + CNT_W'(1);
    end
  end

  assign lnk.paCount = paCount_reg;
  assign lnk.paOvf = inc && (paCount_reg == '1);

  gated_count_a: assert property (@(posedge clock) disable iff (!rstN) // R16
    (lnk.paRun && lnk.paGated && lnk.div64 && enLevel)
    |=> (paCount_reg == $past(paCount_reg) + CNT_W'(1)))
    else $error("gated accumulation missed a divide-by-64 tick");
  pacc_halt_a: assert property (@(posedge clock) disable iff (!rstN) // R12
    !lnk.paRun |=> $stable(paCount_reg))
    else $error("pulse accumulator moved while halted");
endmodule : tcc_pulse_acc
`default_nettype wire

/* File: rtl/tcc_timer_ch7.sv */
// Our own choice: register access over APB.
`default_nettype none
// Functional notes
// R1: a channel 7 event overrides simultaneous compare actions of channels 6 to 0
// R2: on a channel 7 event, each masked-in pin takes its force data bit
// R3: force transfer only where direction is output and pin not disconnected
// R4: force data and system control registers read and write at any time
// R5: main counter is a 16-bit up counter
// R6: software accesses the counter as one word, not two byte halves; the code maps it as two byte registers, high and low
// R7: counter writes ignored unless test mode; reads always allowed
// R8: first count after a test write may be short or long
// R9: timer run bit clear stops the whole timer and counter
// R10: no divide-by-64 clock while the timer is inactive
// R11: halt-in-wait stops timer in wait; its interrupts cannot wake
// R12: halt-in-wait also stops the pulse accumulator in wait
// R13: ch7 pin serves compare output and pulse accumulator input
// R14: each register decoded at base plus its offset
// R15: pulse accumulator runs independently of the timer run bit; in gated mode it stops with the timer, as div64 is gated by timerActive
// R16: gated mode counts divide-by-64 ticks while pin at enabling level
// R17: counter advances per prescaler tick, wraps all ones to zero
// R18: force mask and data reset to zero
module tcc_timer_ch7 (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tcc_pkg::ADDR_W-1:0] paddr,
  input wire logic [tcc_pkg::DATA_W-1:0] pwdata,
  output logic [tcc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic testMode,
  input wire logic cpuWait,
  input wire logic [tcc_pkg::BYTE_W-2:0] chCmpFire,
  input wire logic [tcc_pkg::BYTE_W-2:0] chCmpLevel,
  input wire logic ch7PinIn,
  output logic [tcc_pkg::BYTE_W-1:0] pinOut,
  output logic [tcc_pkg::BYTE_W-1:0] pinOe_n,
  output logic irq
);
  import tcc_pkg::*;

  // ==========================================================
  // reset release
  logic rstMeta_reg;
  logic rstSync_reg;
  logic rstN;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end
  assign rstN = rstSync_reg;

  // ==========================================================
  // declarations
  tcc_link_if lnk ();
  logic [IDX_W-1:0] regIdx;
  logic wrEn;
  logic setupEn;
  logic idxKnown;
  logic [DATA_W-1:0] rdData;
  logic [DATA_W-1:0] prdata_reg;
  logic pslverr_reg;
  logic [BYTE_W-1:0] forceMask_reg;
  logic [BYTE_W-1:0] forceData_reg;
  logic [BYTE_W-1:0] sysCtrl_reg;
  logic [BYTE_W-1:0] dirSel_reg;
  logic [BYTE_W-1:0] pinDis_reg;
  logic toggleOnWrap_reg;
  logic [CNT_W-1:0] cmp7_reg;
  logic [PRESC_SEL_W-1:0] presSel_reg;
  logic [PACC_CTRL_W-1:0] paCtrl_reg;
  logic [IRQ_W-1:0] irqStat_reg;
  logic [IRQ_W-1:0] irqStat_next;
  logic [IRQ_W-1:0] irqMask_reg;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] countInc;
  logic [BYTE_W-1:0] pinOut_reg;
  logic timerRun;
  logic haltInWait;
  logic waitHalt;
  logic wrHigh;
  logic wrLow;
  logic cntLoad;
  logic wrapEv;
  logic matchEv;
  logic ch7Event;
  logic [BYTE_W-1:0] outMode;
  logic [BYTE_W-1:0] forceSel;
  logic [BYTE_W-1:0] otherFire;
  logic [BYTE_W-1:0] otherLevel;
  logic [IRQ_W-1:0] events;

  // ==========================================================
  // apb slave, no wait states, read data caught in setup
  assign regIdx = paddr[ADDR_W-1:2];
  assign wrEn = psel && penable && pwrite;
  assign setupEn = psel && !penable;
  assign pready = psel && penable;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg && psel && penable;

  always_comb begin
    idxKnown = 1'b1;
    rdData = '0;
    case (regIdx) // R14
      IDX_FORCE_MASK: rdData[BYTE_W-1:0] = forceMask_reg;
      IDX_FORCE_DATA: rdData[BYTE_W-1:0] = forceData_reg; // R4
      IDX_COUNT_HIGH: rdData[BYTE_W-1:0] = count_reg[CNT_W-1:BYTE_W]; // R7
      IDX_COUNT_LOW: rdData[BYTE_W-1:0] = count_reg[BYTE_W-1:0];
      IDX_SYS_CTRL: rdData[BYTE_W-1:0] = sysCtrl_reg; // R4
      IDX_CHAN_CFG: begin
        rdData[CFG_DIR_LSB +: BYTE_W] = dirSel_reg;
        rdData[CFG_DIS_LSB +: BYTE_W] = pinDis_reg;
        rdData[CFG_WRAP_BIT] = toggleOnWrap_reg;
      end
      IDX_CMP7: rdData[CNT_W-1:0] = cmp7_reg;
      IDX_PRESC: rdData[PRESC_SEL_W-1:0] = presSel_reg;
      IDX_PACC_CTRL: rdData[PACC_CTRL_W-1:0] = paCtrl_reg;
      IDX_PACC_COUNT: rdData[CNT_W-1:0] = lnk.paCount;
      IDX_IRQ_STAT: rdData[IRQ_W-1:0] = irqStat_reg;
      IDX_IRQ_MASK: rdData[IRQ_W-1:0] = irqMask_reg;
      default: idxKnown = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
    end else if (setupEn) begin
      prdata_reg <= pwrite ? '0 : rdData;
      pslverr_reg <= !idxKnown;
    end
  end

  // ==========================================================
  // software registers
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      forceMask_reg <= FORCE_RST; // R18
      forceData_reg <= FORCE_RST; // R18
    end else if (wrEn) begin
      if (regIdx == IDX_FORCE_MASK) begin
        forceMask_reg <= pwdata[BYTE_W-1:0];
      end
      if (regIdx == IDX_FORCE_DATA) begin
        forceData_reg <= pwdata[BYTE_W-1:0]; // R4
      end
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      sysCtrl_reg <= SYS_RST;
    end else if (wrEn && regIdx == IDX_SYS_CTRL) begin
      sysCtrl_reg <= '0;
      sysCtrl_reg[SYS_RUN_BIT] <= pwdata[SYS_RUN_BIT]; // R4
      sysCtrl_reg[SYS_HALT_BIT] <= pwdata[SYS_HALT_BIT];
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      dirSel_reg <= '0;
      pinDis_reg <= '0;
      toggleOnWrap_reg <= 1'b0;
      cmp7_reg <= '0;
      presSel_reg <= '0;
      paCtrl_reg <= '0;
      irqMask_reg <= '0;
    end else if (wrEn) begin
      case (regIdx)
        IDX_CHAN_CFG: begin
          dirSel_reg <= pwdata[CFG_DIR_LSB +: BYTE_W];
          pinDis_reg <= pwdata[CFG_DIS_LSB +: BYTE_W];
          toggleOnWrap_reg <= pwdata[CFG_WRAP_BIT];
        end
        IDX_CMP7: cmp7_reg <= pwdata[CNT_W-1:0];
        IDX_PRESC: presSel_reg <= pwdata[PRESC_SEL_W-1:0];
        IDX_PACC_CTRL: paCtrl_reg <= pwdata[PACC_CTRL_W-1:0];
        IDX_IRQ_MASK: irqMask_reg <= pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // run control and sub-blocks
  assign timerRun = sysCtrl_reg[SYS_RUN_BIT];
  assign haltInWait = sysCtrl_reg[SYS_HALT_BIT];
  assign waitHalt = haltInWait && cpuWait;
  assign lnk.timerActive = timerRun && !waitHalt; // R9 R11
  assign lnk.presSel = presSel_reg;
  assign lnk.paRun = paCtrl_reg[PACC_RUN_BIT] && !waitHalt; // R12 R15
  assign lnk.paGated = paCtrl_reg[PACC_GATED_BIT];
  assign lnk.paPol = paCtrl_reg[PACC_POL_BIT];
  assign lnk.pinLevel = ch7PinIn; // R13

  tcc_prescaler u_presc (
    .clock(clock),
    .rstN(rstN),
    .lnk(lnk.presc)
  );

  tcc_pulse_acc u_pacc (
    .clock(clock),
    .rstN(rstN),
    .lnk(lnk.pacc)
  );

  // ==========================================================
  // main counter
  assign wrHigh = wrEn && regIdx == IDX_COUNT_HIGH;
  assign wrLow = wrEn && regIdx == IDX_COUNT_LOW;
  assign cntLoad = (wrHigh || wrLow) && testMode; // R7
  assign countInc = count_reg + CNT_W'(1);

  // a test write leaves the prescaler phase alone
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      count_reg <= '0;
    end else if (cntLoad) begin // R8
      if (wrHigh) begin
        count_reg[CNT_W-1:BYTE_W] <= pwdata[BYTE_W-1:0];
      end else begin
        count_reg[BYTE_W-1:0] <= pwdata[BYTE_W-1:0];
      end
    end else if (lnk.tick) begin
      count_reg <= countInc; // R5 R17
    end
  end

  // ==========================================================
  // channel 7 events and pin forcing
  assign wrapEv = lnk.tick && !cntLoad && (count_reg == '1); // R17
  assign matchEv = lnk.tick && !cntLoad && (countInc == cmp7_reg);
  assign ch7Event = matchEv || (wrapEv && toggleOnWrap_reg);
  assign outMode = dirSel_reg & ~pinDis_reg;
  assign forceSel = forceMask_reg & outMode; // R3
  assign otherFire = {1'b0, chCmpFire} & outMode;
  assign otherLevel = {1'b0, chCmpLevel};

  generate
    for (genvar i = 0; i < BYTE_W; i++) begin : g_pin
      always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
          pinOut_reg[i] <= 1'b0;
        end else if (ch7Event && forceSel[i]) begin // R1
          pinOut_reg[i] <= forceData_reg[i]; // R2
        end else if (otherFire[i]) begin
          pinOut_reg[i] <= otherLevel[i];
        end
      end
    end
  endgenerate

  assign pinOut = pinOut_reg;
  assign pinOe_n = ~outMode; // R13

  // ==========================================================
  // interrupt status, write one to clear, set wins
  assign events = {lnk.paOvf, matchEv, wrapEv};

  always_comb begin
    irqStat_next = irqStat_reg;
    if (wrEn && regIdx == IDX_IRQ_STAT) begin
      irqStat_next = irqStat_next & ~pwdata[IRQ_W-1:0];
    end
    irqStat_next = irqStat_next | events;
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      irqStat_reg <= '0;
    end else begin
      irqStat_reg <= irqStat_next;
    end
  end

  assign irq = (|(irqStat_reg & irqMask_reg)) && !waitHalt; // R11

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstN);

  sequence regWriteS(logic [IDX_W-1:0] idx);
    psel && penable && pwrite && regIdx == idx;
  endsequence

  sequence regReadS(logic [IDX_W-1:0] idx);
    psel && !penable && !pwrite && regIdx == idx ##1 psel && penable;
  endsequence

  ch7_priority_a: assert property ( // R1
    ch7Event |=> ((pinOut & $past(forceSel)) == ($past(forceData_reg) & $past(forceSel))))
    else $error("forced pins do not show channel 7 data");
  masked_hold_a: assert property ( // R2
    (ch7Event && otherFire == '0) |=> (((pinOut ^ $past(pinOut)) & ~$past(forceSel)) == '0))
    else $error("masked-off pin changed on channel 7 event");
  force_gate_a: assert property ( // R3
    (ch7Event && forceSel == '0 && otherFire == '0) |=> $stable(pinOut))
    else $error("pin forced without output compare setup");
  data_write_a: assert property ( // R4
    regWriteS(IDX_FORCE_DATA) |=> forceData_reg == $past(pwdata[BYTE_W-1:0]))
    else $error("force data write lost");
  ctrl_read_a: assert property ( // R4
    regReadS(IDX_SYS_CTRL) |-> prdata[BYTE_W-1:0] == sysCtrl_reg)
    else $error("system control read wrong");
  count_up_a: assert property ( // R5
    (lnk.tick && !cntLoad) |=> count_reg == $past(count_reg) + CNT_W'(1))
    else $error("counter did not advance on tick");
  count_lock_a: assert property ( // R7
    (regWriteS(IDX_COUNT_LOW) and (!testMode && !lnk.tick)) |=> $stable(count_reg))
    else $error("counter written outside test mode");
  timer_halt_a: assert property ( // R9
    (!timerRun && !cntLoad) |=> $stable(count_reg))
    else $error("counter moved while timer disabled");
  wait_stop_a: assert property ( // R11
    waitHalt |-> (!lnk.tick && !irq))
    else $error("timer active while halted in wait");
  decode_err_a: assert property ( // R14
    (psel && !penable && !idxKnown) ##1 (psel && penable) |-> pslverr)
    else $error("unmapped access not flagged");
  pacc_free_a: assert property ( // R15
    (paCtrl_reg[PACC_RUN_BIT] && !timerRun && !cpuWait) |-> lnk.paRun)
    else $error("pulse accumulator stopped by timer run bit");
  stat_set_a: assert property ( // R17
    (events != '0) |=> ((irqStat_reg & $past(events)) == $past(events)))
    else $error("status bit lost its event");
  wrap_zero_a: assert property ( // R17
    wrapEv |=> (count_reg == '0))
    else $error("counter did not wrap to zero");
endmodule : tcc_timer_ch7
`default_nettype wire

/* File: verif/test_timer_ch7_compare_control.sv */
`default_nettype none
`define CHK(got, exp) begin checkCount++; if ((got) !== (exp)) begin numErrors++; \
  $display("BAD t=%0t got %0h exp %0h line %0d", $time, (got), (exp), `__LINE__); end end
module test_timer_ch7_compare_control;
  timeunit 1ns;
  timeprecision 100ps;
  import tcc_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic clock = 1'b0;
  logic arstN = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic testMode = 1'b0;
  logic cpuWait = 1'b0;
  logic [BYTE_W-2:0] chCmpFire = '0;
  logic [BYTE_W-2:0] chCmpLevel = '0;
  logic ch7PinIn = 1'b0;
  logic [BYTE_W-1:0] pinOut;
  logic [BYTE_W-1:0] pinOeN;
  logic irq;
  int numErrors = 0;
  int checkCount = 0;
  logic [DATA_W-1:0] rd;
  logic [DATA_W-1:0] base;
  logic err;
  logic [7:0] rowCtl [5] = '{8'h80, 8'h80, 8'hC0, 8'h80, 8'h00};
  logic rowWait [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [7:0] rowSel [5] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
  logic [7:0] rowDiff [5] = '{8'h04, 8'h02, 8'h00, 8'h04, 8'h00};
  always #5 clock = ~clock;
  tcc_timer_ch7 dut_u (
    .clock(clock), .arst_n(arstN), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .testMode(testMode), .cpuWait(cpuWait), .chCmpFire(chCmpFire),
    .chCmpLevel(chCmpLevel), .ch7PinIn(ch7PinIn), .pinOut(pinOut), .pinOe_n(pinOeN),
    .irq(irq)
  );
  // ==========================================================
  // bus tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      numErrors++;
      $display("BAD t=%0t no bus answer", $time);
      summarize();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  task automatic regWrite(input logic [IDX_W-1:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask : regWrite
  task automatic regCheck(input logic [IDX_W-1:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    `CHK(rd, exp)
  endtask : regCheck
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask : idle
  task automatic waitIrq();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (irq !== 1'b1 && n < 200);
    if (n >= 200) begin
      numErrors++;
      $display("BAD t=%0t no interrupt", $time);
      summarize();
    end
  endtask : waitIrq
  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    arstN <= 1'b1;
    repeat (2) @(posedge clock);
    `CHK(pinOeN, 8'hFF)
    `CHK(irq, 1'b0)
    `CHK(pinOut, 8'h00)
    `CHK(pready, 1'b0)
    regCheck(IDX_FORCE_MASK, 32'h0);
    regCheck(IDX_FORCE_DATA, 32'h0);
    regCheck(IDX_SYS_CTRL, 32'h0);
    $display("test reset done");
    regWrite(IDX_FORCE_DATA, 32'hA5);
    regCheck(IDX_FORCE_DATA, 32'hA5);
    regWrite(IDX_SYS_CTRL, 32'hFF);
    regCheck(IDX_SYS_CTRL, 32'hC0);
    regWrite(IDX_SYS_CTRL, 32'h00);
    apb(1'b1, 10'h001, 32'h55);
    `CHK(err, 1'b1)
    apb(1'b0, 10'h001, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    $display("test registers done");
    apb(1'b0, IDX_COUNT_HIGH, 32'h0);
    base = rd;
    regWrite(IDX_COUNT_HIGH, base ^ 32'hFF);
    regCheck(IDX_COUNT_HIGH, base);
    apb(1'b0, IDX_COUNT_LOW, 32'h0);
    base = rd;
    regWrite(IDX_COUNT_LOW, base ^ 32'hFF);
    regCheck(IDX_COUNT_LOW, base);
    testMode <= 1'b1;
    regWrite(IDX_COUNT_HIGH, 32'hFF);
    regWrite(IDX_COUNT_LOW, 32'hF0);
    regCheck(IDX_COUNT_HIGH, 32'hFF);
    idle(20);
    regCheck(IDX_COUNT_LOW, 32'hF0);
    testMode <= 1'b0;
    $display("test counter writes done");
    // ==========================================================
    // pulse accumulator
    regWrite(IDX_PACC_CTRL, 32'h5);
    for (int i = 0; i < 3; i++) begin
      idle(2);
      ch7PinIn <= 1'b1;
      idle(2);
      ch7PinIn <= 1'b0;
    end
    idle(2);
    regCheck(IDX_PACC_COUNT, 32'h3);
    regWrite(IDX_PACC_CTRL, 32'h3);
    ch7PinIn <= 1'b1;
    idle(200);
    regCheck(IDX_PACC_COUNT, 32'h3);
    regWrite(IDX_SYS_CTRL, 32'h80);
    apb(1'b0, IDX_PACC_COUNT, 32'h0);
    base = rd;
    idle(130);
    apb(1'b0, IDX_PACC_COUNT, 32'h0);
    `CHK((rd - base == 2) || (rd - base == 3), 1'b1)
    regWrite(IDX_SYS_CTRL, 32'hC0);
    cpuWait <= 1'b1;
    apb(1'b0, IDX_PACC_COUNT, 32'h0);
    base = rd;
    idle(130);
    regCheck(IDX_PACC_COUNT, base);
    $display("test pulse accumulator done");
    // ==========================================================
    // count rate, run and halt in wait
    for (int i = 0; i < 5; i++) begin
      cpuWait <= rowWait[i];
      regWrite(IDX_PRESC, {24'h0, rowSel[i]});
      regWrite(IDX_SYS_CTRL, {24'h0, rowCtl[i]});
      apb(1'b0, IDX_COUNT_LOW, 32'h0);
      base = rd;
      idle(1);
      apb(1'b0, IDX_COUNT_LOW, 32'h0);
      `CHK(rd[7:0] - base[7:0], rowDiff[i])
    end
    cpuWait <= 1'b0;
    $display("test count rate done");
    // ==========================================================
    // channel 7 events: wrap with toggle, then compare match
    testMode <= 1'b1;
    chCmpLevel <= 7'h7F;
    chCmpFire <= 7'h7F;
    regWrite(IDX_FORCE_MASK, 32'h8F);
    regWrite(IDX_FORCE_DATA, 32'h86);
    regCheck(IDX_IRQ_STAT, 32'h3);
    regWrite(IDX_IRQ_STAT, 32'h7);
    regCheck(IDX_IRQ_STAT, 32'h0);
    for (int k = 0; k < 2; k++) begin
      regWrite(IDX_CHAN_CFG, {15'h0, k == 0, 16'h04FD});
      regWrite(IDX_CMP7, k == 0 ? 32'h1234 : 32'hFFF8);
      regWrite(IDX_IRQ_MASK, k == 0 ? 32'h1 : 32'h2);
      regWrite(IDX_COUNT_HIGH, 32'hFF);
      regWrite(IDX_COUNT_LOW, 32'hF0);
      `CHK(pinOut, k == 0 ? 8'h79 : 8'hF9)
      `CHK(pinOeN, 8'h06)
      regWrite(IDX_SYS_CTRL, 32'h80);
      waitIrq();
      `CHK(pinOut, 8'hF0)
      @(posedge clock);
      #1;
      `CHK(pinOut, 8'hF9)
      regWrite(IDX_SYS_CTRL, 32'h00);
      regCheck(IDX_IRQ_STAT, k == 0 ? 32'h1 : 32'h2);
      regWrite(IDX_IRQ_MASK, 32'h0);
      #1;
      `CHK(irq, 1'b0)
      regWrite(IDX_IRQ_STAT, 32'h7);
      regCheck(IDX_IRQ_STAT, 32'h0);
    end
    $display("test events done");
    summarize();
  end
endmodule : test_timer_ch7_compare_control
`default_nettype wire
